// ### design/mfss_pkg.sv
package mfss_pkg;

    // ==========================================================================
    // register map
    // ==========================================================================
    localparam logic [7:0] MFSS_FAULT_SUBADDR   = 8'h01;
    localparam logic [7:0] MFSS_FAULT_RESET     = 8'h00;

    // ==========================================================================
    // fault status fields
    // ==========================================================================
    localparam int MFSS_BIT_CLEAR   = 7;
    localparam int MFSS_BIT_ILIM    = 4;
    localparam int MFSS_BIT_OTEMP   = 3;
    localparam int MFSS_BIT_UVOLT   = 2;
    localparam int MFSS_BIT_OCUR    = 1;
    localparam int MFSS_BIT_ANY     = 0;

    // ==========================================================================
    // timing
    // ==========================================================================
    localparam int MFSS_CLK_MHZ         = 250;
    localparam int MFSS_WAKE_PULSE_NS   = 1000;
    localparam int MFSS_WAKE_PULSE_CYC  = (MFSS_WAKE_PULSE_NS * MFSS_CLK_MHZ) / 1000;
    localparam int MFSS_ILIM_FILTER_CYC = 64;

    typedef enum logic [1:0] {
        MFSS_SLEEP,
        MFSS_ACTIVE
    } mfss_mode_t;

endpackage : mfss_pkg

// ### design/mfss_sync_if.sv
`timescale 1ns/1ps
interface mfss_sync_if;
    logic [3:0] raw;
    logic [3:0] synced;
    modport owner (output raw, input synced);
    modport sync  (input raw, output synced);
endinterface : mfss_sync_if

// ### design/mfss_sync.sv
`timescale 1ns/1ps
module mfss_sync
(
    input  wire logic   core_clk,   // core clock
    input  wire logic   reset,      // synchronous, active high
    mfss_sync_if.sync   sif         // raw pins in, synchronised out
);
    logic [3:0] stage1_ff;
    logic [3:0] stage2_ff;

    // ==========================================================================
    // two-stage synchroniser; first stage feeds only the second
    // ==========================================================================
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stage1_ff <= 4'h0;
            stage2_ff <= 4'h0;
        end
        else
        begin
            stage1_ff <= sif.raw;
            stage2_ff <= stage1_ff;
        end
    end

    assign sif.synced = stage2_ff;
endmodule : mfss_sync

// ### design/mfss_top.sv
// Overview of operation
// - writing one to bit 7 of the fault register clears all fault flags
// - bit 4 set after prolonged current limiting
// - bit 3 set on over-temperature
// - bit 2 set on supply undervoltage lockout
// - bit 1 set on overcurrent event
// - bit 0 set whenever any fault flag or condition is present
// - both control bits low puts device asleep with outputs high impedance
// - either control bit high wakes device and enables the drivers unless overtemperature, undervoltage or a latched overcurrent is present
// - each wake from sleep pulses the active-low fault output low
// - sense voltage above trip threshold registers an overcurrent
// - undervoltage may resample address pins; interface may then hang
// - fault register at sub-address one, resets to zero, read and cleared
// - thermal shutdown disables bridge, drives fault low, sets flags
// - both control bits zero also clears a latched current-limit fault
`timescale 1ns/1ps
module mfss_top
    import mfss_pkg::*;
#(
    parameter int WAKE_PULSE_CYC  = mfss_pkg::MFSS_WAKE_PULSE_CYC,  // wake pulse length
    parameter int ILIM_FILTER_CYC = mfss_pkg::MFSS_ILIM_FILTER_CYC  // current-limit persistence
)
(
    input  wire logic        core_clk,          // 250 MHz core clock
    input  wire logic        reset,             // synchronous, active high
    input  wire logic [7:0]  reg_addr,          // register sub-address
    input  wire logic        reg_wr,            // one-cycle write strobe
    input  wire logic [7:0]  reg_wdata,         // write data
    input  wire logic        reg_rd,            // one-cycle read strobe
    output logic      [7:0]  reg_rdata,         // read data, valid cycle after reg_rd
    input  wire logic        bridge_ctrl_a,     // control bit a
    input  wire logic        bridge_ctrl_b,     // control bit b
    input  wire logic        sense_over_trip,   // comparator: sense pin above trip threshold
    input  wire logic        current_limiting,  // analog limiter active
    input  wire logic        overtemp_det,      // die over temperature
    input  wire logic        undervolt_det,     // supply below lockout
    output logic             bridge_en,         // bridge drivers enabled
    output logic             bridge_hiz,        // outputs high impedance
    output logic             sleep_state,       // low-power sleep
    output logic             addr_resample,     // undervoltage address resample request
    output logic             fault_alert_low_o, // open-drain pin output value (always 0)
    output logic             fault_alert_low_oe // drives pin low while high
);
    import mfss_pkg::*;

    // ==========================================================================
    // pin synchronisation
    // ==========================================================================
    mfss_sync_if sif ();
    assign sif.raw = {sense_over_trip, current_limiting, overtemp_det, undervolt_det};

    mfss_sync u_sync
    (
        .core_clk (core_clk),
        .reset    (reset),
        .sif      (sif)
    );

    wire overcur_s  = sif.synced[3];
    wire ilim_s     = sif.synced[2];
    wire overtemp_s = sif.synced[1];
    wire uv_s       = sif.synced[0];

    // ==========================================================================
    // state
    // ==========================================================================
    logic [4:0]  flags_ff;
    logic [4:0]  nxt_flags;
    mfss_mode_t  mode_ff;
    mfss_mode_t  nxt_mode;
    logic [15:0] wake_cnt_ff;
    logic [15:0] ilim_cnt_ff;
    logic        uv_prev_ff;

    wire sel_fault  = (reg_addr == MFSS_FAULT_SUBADDR);
    wire clr_write  = reg_wr && sel_fault && reg_wdata[MFSS_BIT_CLEAR];
    wire ctrl_any   = bridge_ctrl_a | bridge_ctrl_b;
    wire ilim_event = ilim_s && (ilim_cnt_ff == 16'(ILIM_FILTER_CYC - 1));
    wire cond_any   = overtemp_s | uv_s;
    wire wake       = (mode_ff == MFSS_SLEEP) && ctrl_any;

    // set terms win over the clear strobe
    always_comb
    begin
        nxt_flags = clr_write ? 5'h00 : flags_ff;
        if (!ctrl_any)
            nxt_flags[MFSS_BIT_ILIM] = 1'b0;
        if (ilim_event)
            nxt_flags[MFSS_BIT_ILIM] = 1'b1;
        if (overtemp_s)
            nxt_flags[MFSS_BIT_OTEMP] = 1'b1;
        if (uv_s)
            nxt_flags[MFSS_BIT_UVOLT] = 1'b1;
        if (overcur_s)
            nxt_flags[MFSS_BIT_OCUR] = 1'b1;
        nxt_flags[MFSS_BIT_ANY] = (|nxt_flags[4:1]) | cond_any;
        nxt_mode = ctrl_any ? MFSS_ACTIVE : MFSS_SLEEP;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            flags_ff    <= MFSS_FAULT_RESET[4:0];
            mode_ff     <= MFSS_SLEEP;
            wake_cnt_ff <= 16'h0000;
            ilim_cnt_ff <= 16'h0000;
            uv_prev_ff  <= 1'b0;
        end
        else
        begin
            flags_ff    <= nxt_flags;
            mode_ff     <= nxt_mode;
            wake_cnt_ff <= wake ? 16'(WAKE_PULSE_CYC)
                         : (wake_cnt_ff != 16'h0000) ? wake_cnt_ff - 16'h0001 : 16'h0000;
            ilim_cnt_ff <= (!ilim_s || ilim_event) ? 16'h0000 : ilim_cnt_ff + 16'h0001;
            uv_prev_ff  <= uv_s;
        end
    end

    // ==========================================================================
    // outputs, all registered
    // ==========================================================================
    wire hard_fault = overtemp_s | uv_s | flags_ff[MFSS_BIT_OCUR];

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            reg_rdata          <= 8'h00;
            bridge_en          <= 1'b0;
            bridge_hiz         <= 1'b1;
            sleep_state        <= 1'b1;
            addr_resample      <= 1'b0;
            fault_alert_low_o  <= 1'b0;
            fault_alert_low_oe <= 1'b0;
        end
        else
        begin
            // clear bit and bits 6..5 always read zero
            reg_rdata          <= (reg_rd && sel_fault) ? {3'b000, flags_ff} : 8'h00;
            bridge_en          <= ctrl_any && !hard_fault;
            bridge_hiz         <= !ctrl_any || hard_fault;
            sleep_state        <= !ctrl_any;
            addr_resample      <= uv_s && !uv_prev_ff;
            fault_alert_low_o  <= 1'b0;
            fault_alert_low_oe <= wake || (wake_cnt_ff > 16'h0001) || flags_ff[MFSS_BIT_ANY];
        end
    end

    // ==========================================================================
    // checks
    // ==========================================================================
    property p_clear;
        @(posedge core_clk) disable iff (reset)
        clr_write && !ilim_event && !overtemp_s && !uv_s && !overcur_s |=> flags_ff == 5'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear write did not clear flags");

    // bridge drop is judged on the next edge only; the bridge may resume once the heat is gone
    property p_overtemp;
        @(posedge core_clk) disable iff (reset)
        overtemp_s |=> flags_ff[MFSS_BIT_OTEMP] && flags_ff[MFSS_BIT_ANY] && !bridge_en;
    endproperty
    a_overtemp: assert property (p_overtemp) else $error("overtemp not flagged");

    property p_uv;
        @(posedge core_clk) disable iff (reset)
        uv_s |=> flags_ff[MFSS_BIT_UVOLT];
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not flagged");

    property p_overcur;
        @(posedge core_clk) disable iff (reset)
        $rose(sense_over_trip) |-> ##3 flags_ff[MFSS_BIT_OCUR];
    endproperty
    a_overcur: assert property (p_overcur) else $error("overcurrent not flagged");

    property p_any;
        @(posedge core_clk) disable iff (reset)
        (|flags_ff[4:1]) |-> flags_ff[MFSS_BIT_ANY];
    endproperty
    a_any: assert property (p_any) else $error("summary flag missing");

    property p_sleep;
        @(posedge core_clk) disable iff (reset)
        !bridge_ctrl_a && !bridge_ctrl_b |=> sleep_state && bridge_hiz && !bridge_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");

    property p_wake;
        @(posedge core_clk) disable iff (reset)
        wake |=> !sleep_state && fault_alert_low_oe ##1 fault_alert_low_oe;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake pulse");

    property p_ilim_clr;
        @(posedge core_clk) disable iff (reset)
        !bridge_ctrl_a && !bridge_ctrl_b && !ilim_event |=> !flags_ff[MFSS_BIT_ILIM];
    endproperty
    a_ilim_clr: assert property (p_ilim_clr) else $error("current limit flag not cleared");

    property p_rd;
        @(posedge core_clk) disable iff (reset)
        ##1 reg_rdata[7:5] == 3'b000;
    endproperty
    a_rd: assert property (p_rd) else $error("unused bits not zero");

    property p_ilim;
        @(posedge core_clk) disable iff (reset)
        ilim_event |=> flags_ff[MFSS_BIT_ILIM];
    endproperty
    a_ilim: assert property (p_ilim) else $error("current limit not flagged");

    property p_en;
        @(posedge core_clk) disable iff (reset)
        bridge_ctrl_a && !overtemp_s && !uv_s && !flags_ff[MFSS_BIT_OCUR] |=> bridge_en;
    endproperty
    a_en: assert property (p_en) else $error("bridge not enabled");

    c_wake:  cover property (@(posedge core_clk) disable iff (reset) wake);
    c_clear: cover property (@(posedge core_clk) disable iff (reset) clr_write && flags_ff != 5'h00);
    c_ilim:  cover property (@(posedge core_clk) disable iff (reset) ilim_event);
    c_overtemp: cover property (@(posedge core_clk) disable iff (reset) overtemp_s && bridge_ctrl_a);

endmodule : mfss_top

// ### testbench/mfss_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// controller model: register strobes and bridge control bits
// ==========================================================================
module mfss_host_model
(
    input  wire logic       core_clk,      // core clock
    output logic      [7:0] reg_addr,      // sub-address
    output logic            reg_wr,        // write strobe
    output logic      [7:0] reg_wdata,     // write data
    output logic            reg_rd,        // read strobe
    input  wire logic [7:0] reg_rdata,     // read data
    output logic            bridge_ctrl_a, // control bit a
    output logic            bridge_ctrl_b  // control bit b
);
    initial
    begin
        reg_addr      = 8'h00;
        reg_wr        = 1'b0;
        reg_wdata     = 8'h00;
        reg_rd        = 1'b0;
        bridge_ctrl_a = 1'b0;
        bridge_ctrl_b = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        // stale data must not look valid once the strobe is gone
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
    endtask : rd

    task automatic ctrl(input logic a, input logic b);
        @(negedge core_clk);
        bridge_ctrl_a = a;
        bridge_ctrl_b = b;
    endtask : ctrl
endmodule : mfss_host_model

// ### testbench/tb_motor_fault_status_sleep.sv
`timescale 1ns/1ps
module tb_motor_fault_status_sleep;
    import mfss_pkg::*;
    localparam int WPC = 4;
    logic       core_clk = 1'b0;
    logic       reset    = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic       reg_wr, reg_rd, ctrl_a, ctrl_b, bridge_en, bridge_hiz, sleep_state;
    logic       addr_resample, alert_o, alert_oe;
    logic [3:0] src      = 4'h0;
    int         n_fail   = 0;
    int         checks_done = 0;
    int         cyc      = 0;
    int         n_resamp = 0;
    int         n;

    always #2 core_clk = ~core_clk;

    mfss_top #(.WAKE_PULSE_CYC(WPC), .ILIM_FILTER_CYC(4)) i_mfss_top (.core_clk(core_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bridge_ctrl_a(ctrl_a), .bridge_ctrl_b(ctrl_b), .sense_over_trip(src[3]), .current_limiting(src[0]),
        .overtemp_det(src[1]), .undervolt_det(src[2]), .bridge_en(bridge_en), .bridge_hiz(bridge_hiz),
        .sleep_state(sleep_state), .addr_resample(addr_resample), .fault_alert_low_o(alert_o),
        .fault_alert_low_oe(alert_oe));

    mfss_host_model i_mfss_host_model (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bridge_ctrl_a(ctrl_a),
        .bridge_ctrl_b(ctrl_b));

    always @(negedge core_clk)
    begin
        if (addr_resample === 1'b1)
            n_resamp++;
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic waitn(input int k);
        repeat (k) @(negedge core_clk);
    endtask : waitn

    task automatic t_reset();
        i_mfss_host_model.rd(MFSS_FAULT_SUBADDR, d);
        chk("fault reg reset", MFSS_FAULT_RESET, d);
        chk("sleep after reset", 8'h01, {7'h00, sleep_state});
        chk("hiz after reset", 8'h01, {7'h00, bridge_hiz});
        $display("test reset done");
    endtask : t_reset

    task automatic t_wake();
        n = 0;
        i_mfss_host_model.ctrl(1'b1, 1'b0);
        repeat (12)
        begin
            @(negedge core_clk);
            if (alert_oe === 1'b1 && alert_o === 1'b0)
                n++;
        end
        chk("wake pulse cycles", 8'(WPC), 8'(n));
        chk("awake bridge_en", 8'h01, {7'h00, bridge_en});
        chk("awake sleep", 8'h00, {7'h00, sleep_state});
        $display("test wake done");
    endtask : t_wake

    task automatic t_faults();
        logic [7:0] e;
        for (int i = 0; i < 4; i++)
        begin
            e = 8'h01 | (8'h01 << (4 - i));
            src[i] = 1'b1;
            waitn(10);
            if (i == 1)
                chk("overtemp bridge_en", 8'h00, {7'h00, bridge_en});
            if (i == 1)
                chk("overtemp alert oe", 8'h01, {7'h00, alert_oe});
            src[i] = 1'b0;
            waitn(4);
            i_mfss_host_model.rd(MFSS_FAULT_SUBADDR, d);
            chk("cause flag", e, d);
            i_mfss_host_model.wr(MFSS_FAULT_SUBADDR, 8'h7F);
            i_mfss_host_model.wr(8'h00, 8'h80);
            i_mfss_host_model.rd(MFSS_FAULT_SUBADDR, d);
            chk("ignored writes", e, d);
            i_mfss_host_model.wr(MFSS_FAULT_SUBADDR, 8'h80);
            i_mfss_host_model.rd(MFSS_FAULT_SUBADDR, d);
            chk("after clear", 8'h00, d);
        end
        chk("resample pulses", 8'h01, 8'(n_resamp));
        i_mfss_host_model.rd(8'h02, d);
        chk("unmapped read", 8'h00, d);
        $display("test faults done");
    endtask : t_faults

    task automatic t_sleep_clear();
        src[0] = 1'b1;
        waitn(10);
        src[0] = 1'b0;
        waitn(4);
        i_mfss_host_model.rd(MFSS_FAULT_SUBADDR, d);
        chk("ilim latched", 8'h11, d);
        i_mfss_host_model.ctrl(1'b0, 1'b0);
        waitn(2);
        i_mfss_host_model.rd(MFSS_FAULT_SUBADDR, d);
        chk("ilim cleared by sleep", 8'h00, d);
        chk("sleep entered", 8'h01, {7'h00, sleep_state});
        chk("sleep hiz", 8'h01, {7'h00, bridge_hiz});
        i_mfss_host_model.ctrl(1'b1, 1'b1);
        waitn(2);
        chk("brake wakes", 8'h01, {7'h00, bridge_en});
        i_mfss_host_model.ctrl(1'b0, 1'b0);
        waitn(2);
        i_mfss_host_model.ctrl(1'b0, 1'b1);
        waitn(2);
        chk("reverse wakes", 8'h01, {7'h00, bridge_en});
        $display("test sleep clear done");
    endtask : t_sleep_clear

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial
    begin
        waitn(10);
        reset = 1'b0;
        t_reset();
        t_wake();
        t_faults();
        t_sleep_clear();
        test_done();
    end
endmodule : tb_motor_fault_status_sleep
